// [sltr_consts.vh]
// Constants of the slot and link tuning register bank: byte offsets,
// field positions and reset values.
// Assumes inclusion by the bank module only; definitions only.
`ifndef SLTR_CONSTS_VH
`define SLTR_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// Byte offsets of the register words
`define SLTR_OFS_SLOT_CAP      8'hC4
`define SLTR_OFS_SLOT_CTLSTS   8'hC8
`define SLTR_OFS_TUNE0         8'hCC
`define SLTR_OFS_TUNE1         8'hD0
`define SLTR_OFS_TUNE2         8'hD4

////////////////////////////////////////////////////////////////////////
// Slot capability bit positions
`define SLTR_CAP_ATTN_BTN      0
`define SLTR_CAP_PWR_CTRL      1
`define SLTR_CAP_LATCH_SENSOR  2
`define SLTR_CAP_ATTN_IND      3
`define SLTR_CAP_PWR_IND       4
`define SLTR_CAP_SURPRISE      5
`define SLTR_CAP_HP_CAPABLE    6

////////////////////////////////////////////////////////////////////////
// Slot control and status fields
`define SLTR_CTL_EVT_LSB       0
`define SLTR_CTL_ATTN_LSB      6
`define SLTR_CTL_PIND_LSB      8
`define SLTR_CTL_PWRC_BIT      10
`define SLTR_STS_LSB           16
`define SLTR_CTL_RESET         11'h000
`define SLTR_STS_RESET         7'h00

////////////////////////////////////////////////////////////////////////
// Tuning word 0 fields
`define SLTR_T0_EN_LSB         0
`define SLTR_T0_NEG_LSB        5
`define SLTR_T0_TS1_LSB        8
`define SLTR_T0_L1T_LSB        16
`define SLTR_T0_EN_RESET       5'h00
`define SLTR_T0_NEG_RESET      3'h3
`define SLTR_T0_TS1_RESET      5'h10
`define SLTR_T0_L1T_RESET      16'h0400

////////////////////////////////////////////////////////////////////////
// Tuning word 1 and 2 fields
`define SLTR_T1_L0S_LSB        0
`define SLTR_T1_L1_LSB         16
`define SLTR_T1_L0S_RESET      10'h000
`define SLTR_T1_L1_RESET       16'h0000
`define SLTR_T2_CR_LSB         0
`define SLTR_T2_L0SX_LSB       8
`define SLTR_T2_L1X_LSB        16
`define SLTR_T2_CR_RESET       8'h54
`define SLTR_T2_L0SX_RESET     7'h02
`define SLTR_T2_L1X_RESET      7'h19

////////////////////////////////////////////////////////////////////////
// Ordered set make-up used for clock recovery
`define SLTR_FTS_SYMBOLS       4

`endif

// [sltr_regs.v]
// Slot hot-plug and physical link tuning register bank behind an APB
// slave, with every control field brought out as a register output.
// Assumes synchronous inputs on pclk and a hot-plug strap that is
// stable around the release of presetn.
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`include "sltr_consts.vh"

module sltr_regs #(
  parameter AW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          pce,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  input  wire [3:0]    pstrb,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire          hp_strap,
  input  wire          slot_btn_pressed,
  input  wire          slot_pwr_fault,
  input  wire          slot_latch_changed,
  input  wire          slot_presence_changed,
  input  wire          slot_cmd_completed,
  input  wire          slot_latch_state,
  input  wire          slot_presence_state,
  output wire [5:0]    slot_event_en,
  output wire [1:0]    attn_ind_ctrl,
  output wire [1:0]    pwr_ind_ctrl,
  output wire          pwr_ctrl,
  output wire          hot_reset_en,
  output wire          loopback_en,
  output wire          crosslink_en,
  output wire          sw_cfg_entry_en,
  output wire          debug_sel,
  output wire [2:0]    lane_neg_retries,
  output wire [4:0]    ts1_count,
  output wire [15:0]   l1_entry_timer,
  output wire [9:0]    l0s_lifetime,
  output wire [15:0]   l1_lifetime,
  output wire [7:0]    clock_recovery_fts,
  output reg  [9:0]    clock_recovery_symbols,
  output wire [6:0]    l0s_exit_latency,
  output wire [6:0]    l1_exit_latency
);

  //////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a write into a stored word
  function [31:0] sltr_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    input [31:0] wmask;
    integer      i;
    begin
      sltr_merge = old_val;
      for (i = 0; i < 32; i = i + 1) begin
        if (strb[i/8] && wmask[i])
          sltr_merge[i] = new_val[i];
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Storage
  reg [10:0] slot_ctl_reg;
  reg [6:0]  slot_sts_reg;
  reg [31:0] tune0_reg;
  reg [31:0] tune1_reg;
  reg [31:0] tune2_reg;
  reg        hp_en_reg;
  reg        strap_done_reg;

  wire [31:0] ctl_word;
  wire [31:0] cap_word;
  wire [31:0] tune0_next;
  wire [31:0] tune1_next;
  wire [31:0] tune2_next;
  wire [31:0] ctl_next;
  wire        wr_acc;
  wire        rd_acc;
  wire        hit;
  reg  [31:0] rd_word;

  //////////////////////////////////////////////////////////////////////
  // APB handshake: zero wait states, unmapped offsets flag an error
  assign pready  = 1'b1;
  assign hit     = (paddr == `SLTR_OFS_SLOT_CAP) ||
                   (paddr == `SLTR_OFS_SLOT_CTLSTS) ||
                   (paddr == `SLTR_OFS_TUNE0) ||
                   (paddr == `SLTR_OFS_TUNE1) ||
                   (paddr == `SLTR_OFS_TUNE2);
  assign pslverr = psel & penable & ~hit;
  assign wr_acc  = pce & psel & penable & pwrite & hit;
  assign rd_acc  = pce & psel & penable & ~pwrite;

  //////////////////////////////////////////////////////////////////////
  // Strap capture after reset release
  // The strap is sampled by a clocked process, never loaded by reset,
  // so the strap-driven capability bits show 0 during reset and the strap level
  // from the first enabled edge after release onward.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_en_reg      <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (pce && !strap_done_reg) begin
      hp_en_reg      <= hp_strap;
      strap_done_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Capability word
  // Strap drives capability bits 0, 2, 3, 4 and 6; power control and surprise read 0
  // Power limit and slot number zero
  assign cap_word = {25'h0000000,
                     hp_en_reg,
                     1'b0,
                     hp_en_reg,
                     hp_en_reg,
                     hp_en_reg,
                     1'b0,
                     hp_en_reg};

  //////////////////////////////////////////////////////////////////////
  // Write data merged per byte lane with writable-bit masks
  // Slot control RW
  assign ctl_next = sltr_merge({21'h000000, slot_ctl_reg}, pwdata, pstrb,
                               32'h000007FF);
  assign tune0_next = sltr_merge(tune0_reg, pwdata, pstrb, 32'hFFFF1FFF);
  assign tune1_next = sltr_merge(tune1_reg, pwdata, pstrb, 32'hFFFF03FF);
  assign tune2_next = sltr_merge(tune2_reg, pwdata, pstrb, 32'h007F7FFF);

  //////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_ctl_reg <= `SLTR_CTL_RESET;
      tune0_reg[4:0]   <= `SLTR_T0_EN_RESET;
      tune0_reg[7:5]   <= `SLTR_T0_NEG_RESET;
      tune0_reg[12:8]  <= `SLTR_T0_TS1_RESET;
      tune0_reg[15:13] <= 3'h0;
      tune0_reg[31:16] <= `SLTR_T0_L1T_RESET;
      tune1_reg[9:0]   <= `SLTR_T1_L0S_RESET;
      tune1_reg[15:10] <= 6'h00;
      tune1_reg[31:16] <= `SLTR_T1_L1_RESET;
      tune2_reg[7:0]   <= `SLTR_T2_CR_RESET;
      tune2_reg[14:8]  <= `SLTR_T2_L0SX_RESET;
      tune2_reg[15]    <= 1'b0;
      tune2_reg[22:16] <= `SLTR_T2_L1X_RESET;
      tune2_reg[31:23] <= 9'h000;
    end else if (wr_acc) begin
      case (paddr)
        `SLTR_OFS_SLOT_CTLSTS: begin
          slot_ctl_reg <= ctl_next[10:0];
        end
        `SLTR_OFS_TUNE0: begin
          tune0_reg <= tune0_next;
        end
        `SLTR_OFS_TUNE1: begin
          tune1_reg <= tune1_next;
        end
        `SLTR_OFS_TUNE2: begin
          tune2_reg <= tune2_next;
        end
        default: begin
          tune0_reg <= tune0_reg;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Slot status shadows the slot hardware; software cannot write it
  // Status read-only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_sts_reg <= `SLTR_STS_RESET;
    end else if (pce) begin
      slot_sts_reg <= {slot_presence_state,
                       slot_latch_state,
                       slot_cmd_completed,
                       slot_presence_changed,
                       slot_latch_changed,
                       slot_pwr_fault,
                       slot_btn_pressed};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Clock recovery length in symbols for the training sequencer
  // Four symbols per set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_recovery_symbols <= 10'h000;
    end else if (pce) begin
      clock_recovery_symbols <= {tune2_reg[7:0], 2'b00};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits and unmapped offsets read zero
  assign ctl_word = {9'h000, slot_sts_reg, 5'h00, slot_ctl_reg};

  always @* begin
    case (paddr)
      `SLTR_OFS_SLOT_CAP:    rd_word = cap_word;
      `SLTR_OFS_SLOT_CTLSTS: rd_word = ctl_word;
      `SLTR_OFS_TUNE0:       rd_word = tune0_reg;
      `SLTR_OFS_TUNE1:       rd_word = tune1_reg;
      `SLTR_OFS_TUNE2:       rd_word = tune2_reg;
      default:               rd_word = 32'h00000000;
    endcase
  end

  // Read data is registered during setup so it is stable in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (pce && psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end else if (rd_acc) begin
      prdata <= prdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Field outputs
  assign slot_event_en    = slot_ctl_reg[5:0];
  assign attn_ind_ctrl    = slot_ctl_reg[7:6];
  assign pwr_ind_ctrl     = slot_ctl_reg[9:8];
  assign pwr_ctrl         = slot_ctl_reg[10];
  assign hot_reset_en     = tune0_reg[0];
  assign loopback_en      = tune0_reg[1];
  assign crosslink_en     = tune0_reg[2];
  assign sw_cfg_entry_en  = tune0_reg[3];
  assign debug_sel        = tune0_reg[4];
  assign lane_neg_retries = tune0_reg[7:5];
  assign ts1_count        = tune0_reg[12:8];
  assign l1_entry_timer   = tune0_reg[31:16];
  assign l0s_lifetime     = tune1_reg[9:0];
  assign l1_lifetime      = tune1_reg[31:16];
  assign clock_recovery_fts = tune2_reg[7:0];
  assign l0s_exit_latency = tune2_reg[14:8];
  assign l1_exit_latency  = tune2_reg[22:16];

endmodule // sltr_regs

// [sltr_slot_model.sv]
// Slot hardware model: drives the seven slot status levels.
// Assumes the bench clock; pins change just after rising edges.
`timescale 1ns/100ps
module sltr_slot_model (
  input  wire       pclk,
  input  wire [6:0] level,
  output reg  [6:0] pins
);
  initial pins = 7'h00;
  always @(posedge pclk) pins <= level;
endmodule // sltr_slot_model

// [sltr_regs_assertions.sv]
// Checker of the slot and link tuning register bank.
// Assumes binding to sltr_regs; one clock pclk, reset presetn.
`timescale 1ns/100ps
module sltr_regs_check #(
  parameter AW = 8
) (
  input wire          pclk,
  input wire          presetn,
  input wire          pce,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0]   pwdata,
  input wire [3:0]    pstrb,
  input wire [31:0]   prdata,
  input wire          pslverr,
  input wire          hp_strap,
  input wire [5:0]    slot_event_en,
  input wire [1:0]    attn_ind_ctrl,
  input wire [1:0]    pwr_ind_ctrl,
  input wire          pwr_ctrl,
  input wire [2:0]    lane_neg_retries,
  input wire [4:0]    ts1_count,
  input wire [15:0]   l1_entry_timer,
  input wire [15:0]   l1_lifetime,
  input wire [7:0]    clock_recovery_fts,
  input wire [9:0]    clock_recovery_symbols,
  input wire [6:0]    l1_exit_latency
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_set = psel && !penable && !pwrite && pce;
  wire wr_acc = psel && penable && pwrite && pce;
  wire mapped = paddr == 8'hC4 || paddr == 8'hC8 || paddr == 8'hCC ||
                paddr == 8'hD0 || paddr == 8'hD4;
  //////////////////////////////////////////////////////////////////////
  cap_bits_a: assert property (
    rd_set && paddr == 8'hC4 |=> prdata == (hp_strap ? 32'h5D : 32'h0))
    else $error("slot capability word wrong");
  slv_err_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error flag does not match address map");
  bad_read_a: assert property (
    psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  ctl_write_a: assert property (
    wr_acc && paddr == 8'hC8 && pstrb[1:0] == 2'b11 |=>
    {pwr_ctrl, pwr_ind_ctrl, attn_ind_ctrl, slot_event_en}
      == $past(pwdata[10:0]))
    else $error("slot control fields not written");
  tune_write_a: assert property (
    wr_acc && paddr == 8'hCC && pstrb == 4'hF |=>
    {l1_entry_timer, ts1_count, lane_neg_retries} ==
      {$past(pwdata[31:16]), $past(pwdata[12:8]), $past(pwdata[7:5])})
    else $error("tuning word 0 fields not written");
  reset_vals_a: assert property (
    $rose(presetn) |-> lane_neg_retries == 3'h3 && ts1_count == 5'h10 &&
    l1_entry_timer == 16'h0400 && clock_recovery_fts == 8'h54 &&
    l1_exit_latency == 7'h19)
    else $error("field reset value wrong");
  fts_symbols_a: assert property (
    pce |=> clock_recovery_symbols == {$past(clock_recovery_fts), 2'b00})
    else $error("symbol count not four per set");
  life_hold_a: assert property (
    !(wr_acc && paddr == 8'hD0) |=> $stable(l1_lifetime))
    else $error("lifetime timer changed without write");
  lane_strobe_a: assert property (
    wr_acc && paddr == 8'hD4 && !pstrb[2] |=> $stable(l1_exit_latency))
    else $error("masked byte lane written");
  freeze_a: assert property (!pce |=> $stable(prdata) && $stable(ts1_count))
    else $error("state moved with clock enable low");
endmodule // sltr_regs_check
bind sltr_regs sltr_regs_check #(.AW(AW)) chk (.*);

// [sltr_regs_test.sv]
// Self-checking bench of the slot and link tuning register bank.
// Assumes the bound checker and the slot model beside the bank.
`timescale 1ns/100ps
module sltr_regs_test;
  logic        pclk = 1'b0, presetn = 1'b0, pce = 1'b1, hp_strap = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h7, a_d;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, pwr_ctrl, hot_reset_en, loopback_en;
  logic        crosslink_en, sw_cfg_entry_en, debug_sel;
  logic [6:0]  lvl = 7'h00, pins, l0s_exit_latency, l1_exit_latency;
  logic [5:0]  slot_event_en;
  logic [1:0]  attn_ind_ctrl, pwr_ind_ctrl;
  logic [2:0]  lane_neg_retries;
  logic [4:0]  ts1_count;
  logic [15:0] l1_entry_timer, l1_lifetime;
  logic [9:0]  l0s_lifetime, clock_recovery_symbols;
  logic [7:0]  clock_recovery_fts, a;
  wire         slot_btn_pressed, slot_pwr_fault, slot_latch_changed;
  wire         slot_presence_changed, slot_cmd_completed;
  wire         slot_latch_state, slot_presence_state;
  logic [31:0] mdl [5];
  logic [32:0] q [$];
  logic [97:0] qf [$];
  int          n_errors = 0, num_checks = 0, cycles = 0, i;
  localparam logic [31:0] WM [5] = '{32'h0, 32'h7FF, 32'hFFFF1FFF,
                                     32'hFFFF03FF, 32'h7F7FFF};
  assign {slot_presence_state, slot_latch_state, slot_cmd_completed,
          slot_presence_changed, slot_latch_changed, slot_pwr_fault,
          slot_btn_pressed} = pins;
  sltr_regs dut (.*);
  sltr_slot_model slot (.pclk(pclk), .level(lvl), .pins(pins));
  initial forever #25 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic ok(input logic [7:0] x);
    return x >= 8'hC4 && x <= 8'hD4 && x[1:0] == 2'b00;
  endfunction
  task automatic check(input logic [32:0] exp, input logic [32:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  // Field outputs against the model, one note per completed read
  task automatic check_fld(input logic [97:0] exp, input logic [97:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic conclude;
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] x,
                      input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= x;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] x, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & WM[(x - 8'hC4) >> 2];
    if (ok(x) && pce) mdl[(x - 8'hC4) >> 2] =
      (mdl[(x - 8'hC4) >> 2] & ~m) | (d & m);
    xfer(1'b1, x, d, s);
  endtask
  task automatic rd(input logic [7:0] x);
    logic [31:0] e;
    e = ok(x) ? mdl[(x - 8'hC4) >> 2] : 32'h0;
    if (x == 8'hC8) e = e | {9'h0, lvl, 16'h0};
    q.push_back({!ok(x), e});
    qf.push_back({mdl[1][10:0], mdl[2][31:16], mdl[2][12:0], mdl[3][31:16],
                  mdl[3][9:0], mdl[4][22:16], mdl[4][14:0],
                  mdl[4][7:0], 2'b00});
    xfer(1'b0, x, 32'h0, 4'h0);
  endtask
  task automatic do_reset(input logic s);
    hp_strap <= s;
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    mdl = '{s ? 32'h5D : 32'h0, 32'h0, 32'h04001060, 32'h0, 32'h00190254};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  // Result watcher: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0)
      check(q.pop_front(), {pslverr, prdata});
    if (psel && penable && pready && !pwrite && qf.size() > 0)
      check_fld(qf.pop_front(),
                {pwr_ctrl, pwr_ind_ctrl, attn_ind_ctrl, slot_event_en,
                 l1_entry_timer, ts1_count, lane_neg_retries, debug_sel,
                 sw_cfg_entry_en, crosslink_en, loopback_en, hot_reset_en,
                 l1_lifetime, l0s_lifetime, l1_exit_latency,
                 l0s_exit_latency, clock_recovery_fts,
                 clock_recovery_symbols});
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    do_reset(1'b1);
    for (i = 0; i < 7; i++) rd(8'(8'hC4 + 4 * i));
    // Random back-to-back traffic; index 5 lands on an unmapped word
    for (i = 0; i < 60; i++) begin
      lfsr = rnd(lfsr);
      a_d = rnd(lfsr);
      lvl <= lfsr[6:0];
      a = 8'(8'hC4 + 4 * (lfsr[10:8] % 6));
      wr(a, a_d, lfsr[16] ? 4'hF : lfsr[15:12]);
      rd(a);
      lfsr = a_d;
    end
    pce <= 1'b0;
    @(posedge pclk);
    wr(8'hCC, 32'h0, 4'hF);
    pce <= 1'b1;
    rd(8'hCC);
    do_reset(1'b0);
    for (i = 0; i < 5; i++) rd(8'(8'hC4 + 4 * i));
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
    conclude();
  end
endmodule // sltr_regs_test
